// ===== core/rtd_buf2.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes both sides run on clk_sys.
`timescale 1ns/100ps
module rtd_buf2 #(
    parameter int WIDTH = 24
) (
    // Clock and reset
    input  logic             clk_sys,
    input  logic             rst_n,
    // Filling side
    input  logic             in_valid,
    output logic             in_ready,
    input  logic [WIDTH-1:0] in_data,
    // Draining side
    output logic             out_valid,
    input  logic             out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [2];  // Storage
    logic             wp;        // Write slot
    logic             rp;        // Read slot
    logic [1:0]       cnt;       // Entries held
    logic [1:0]       next_cnt;  // Entries after this edge
    logic             push;      // Word taken in
    logic             pop;       // Word handed out

    assign push     = in_valid & in_ready;
    assign pop      = out_valid & out_ready;
    assign next_cnt = cnt + {1'b0, push} - {1'b0, pop};
    assign out_data = mem[rp];

    // Occupancy and registered handshake flags
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt       <= 2'h0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
            wp        <= 1'b0;
            rp        <= 1'b0;
        end else begin
            cnt       <= next_cnt;
            in_ready  <= next_cnt != 2'h2;
            out_valid <= next_cnt != 2'h0;
            if (push) wp <= ~wp;
            if (pop) rp <= ~rp;
        end
    end

    // Data slots, not reset
    always_ff @(posedge clk_sys) begin
        if (push) mem[wp] <= in_data;
    end

    a_buf_full: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !in_ready |-> cnt == 2'h2) else $error("buffer refuses while not full");
    a_buf_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("stalled word changed or vanished");
endmodule

// ===== core/rtd_core.sv
// Beat-interval detector: config registers, detector, ECG sample FIFO, SPI.
// Assumes samples and an 8 ms detector tick arrive on clk_sys, and the
// SPI pins come from another clock domain.
`timescale 1ns/100ps
module rtd_core (
    // Clock and reset
    input  logic                clk_sys,
    input  logic                rst_n,
    // SPI pins
    input  logic                sclk,
    input  logic                csb_n,
    input  logic                sdi,
    output logic                sdo,
    output logic                sdo_oe,
    // Sample stream from the front end
    input  logic                sample_in_valid,
    output logic                sample_in_ready,
    input  rtd_pkg::rtd_sample_t sample_in,
    // Detector timing and channel state
    input  logic                detect_tick,
    input  logic                ecg_channel_enable,
    // FIFO control
    input  logic                fifo_reset_cmd,
    input  logic                resync_cmd,
    input  logic [4:0]          sample_fifo_irq_threshold,
    // Interrupt terms
    output logic                sample_fifo_irq,
    output logic                sample_fifo_overflow,
    output logic                beat_irq,
    input  logic                beat_irq_clear
);
    // Weighted running average, weight 2^(sel+1)
    function automatic logic [23:0] rtd_wavg(input logic [23:0] nw,
                                             input logic [23:0] avg,
                                             input logic [1:0]  sel);
        logic [28:0] acc;
        acc = ({5'h00, avg} << ({1'b0, sel} + 3'h1)) - {5'h00, avg} + {5'h00, nw};
        // Divide by the weight; the sum never needs more than 24 bits after it
        return 24'(acc >> ({1'b0, sel} + 3'h1));
    endfunction

    // Shift left by the gain code, saturating at 24 bits
    function automatic logic [23:0] rtd_gain(input logic [17:0] m,
                                             input logic [3:0]  s);
        logic [41:0] w;
        w = {24'h000000, m} << s;
        return (|w[41:24]) ? 24'hFFFFFF : w[23:0];
    endfunction

    // Pin synchronisers, [0] is the first stage
    logic [2:0]  sclk_sync;
    logic [2:0]  csb_sync;
    logic [2:0]  sdi_sync;
    logic        sclk_f;           // Agreed SCLK level
    logic        csb_f;            // Agreed chip-select level
    logic        next_sclk_f;
    logic        next_csb_f;
    logic        spi_rise;         // SCLK rising while selected
    logic        spi_fall;         // SCLK falling while selected
    logic        sdi_bit;          // Data bit at this edge
    // SPI transaction state
    rtd_pkg::rtd_spi_state_t state;
    logic [5:0]  edge_cnt;         // Rising edges so far in this word
    logic [5:0]  edge_no;          // Number of the edge now arriving
    logic        word_end;
    logic [7:0]  cmd_sr;
    logic [6:0]  addr;
    logic [23:0] wr_sr;
    logic [23:0] wr_data;
    logic [23:0] rd_sr;
    logic [23:0] read_word;
    logic        load_pending;     // Fetch the next read word
    logic        is_fifo_addr;
    logic        burst;
    logic        cfg_write;
    // Config registers
    logic [23:0] gain_cfg;
    logic [23:0] timing_cfg;
    // Sample FIFO
    rtd_pkg::rtd_sample_t mem [32];
    rtd_pkg::rtd_sample_t head;
    rtd_pkg::rtd_sample_t buf_data;
    logic [5:0]  wr_ptr;
    logic [5:0]  rd_ptr;
    logic [5:0]  fifo_count;
    logic [5:0]  thr_n;
    logic        fifo_full;
    logic        fifo_empty;
    logic        fifo_clear;
    logic        fifo_pop;
    logic        fifo_accept;
    logic        fifo_push;
    logic        fifo_push_full;
    logic        buf_out_valid;
    logic        buf_out_ready;
    logic [2:0]  head_tag;
    // Detector
    logic        det_on;
    logic        det_sample;
    logic [17:0] mag;
    logic [3:0]  gain_code;
    logic [3:0]  gain_shift;
    logic [23:0] scaled;
    logic [31:0] win_acc;
    logic [5:0]  win_ticks;
    logic [5:0]  win_len;
    logic        win_close;
    logic [23:0] feature;
    logic [23:0] peak_avg;
    logic [28:0] thr_prod;
    logic [13:0] interval_cnt;
    logic [13:0] interval_avg;
    logic [23:0] next_interval_avg;
    logic [16:0] dyn_prod;
    logic [13:0] holdoff;
    logic [13:0] beat_interval;
    logic        beat;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Three-stage capture; a level counts once stages two and three agree
    assign next_sclk_f = (sclk_sync[1] == sclk_sync[2]) ? sclk_sync[2] : sclk_f;
    assign next_csb_f  = (csb_sync[1] == csb_sync[2]) ? csb_sync[2] : csb_f;
    assign spi_rise    = next_sclk_f & ~sclk_f & ~csb_f;
    assign spi_fall    = ~next_sclk_f & sclk_f & ~csb_f;
    assign sdi_bit     = sdi_sync[2];

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sclk_sync <= 3'h0;
            csb_sync  <= 3'h7;
            sdi_sync  <= 3'h0;
            sclk_f    <= 1'b0;
            csb_f     <= 1'b1;
        end else begin
            sclk_sync <= {sclk_sync[1:0], sclk};
            csb_sync  <= {csb_sync[1:0], csb_n};
            sdi_sync  <= {sdi_sync[1:0], sdi};
            sclk_f    <= next_sclk_f;
            csb_f     <= next_csb_f;
        end
    end

    // Edge numbering: after edge 32 a burst word restarts at edge 9
    assign edge_no      = (edge_cnt == rtd_pkg::WORD_END_EDGE) ? rtd_pkg::NEXT_WORD_EDGE
                                                                : edge_cnt + 6'h01;
    assign word_end     = edge_no == rtd_pkg::WORD_END_EDGE;
    assign wr_data      = {wr_sr[22:0], sdi_bit};
    assign is_fifo_addr = (addr == rtd_pkg::ADDR_FIFO_BURST) |
                          (addr == rtd_pkg::ADDR_FIFO_SINGLE);
    assign burst        = addr == rtd_pkg::ADDR_FIFO_BURST;
    assign cfg_write    = spi_rise & (state == rtd_pkg::SPI_WRITE) & word_end;

    // SPI transaction sequencer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state        <= rtd_pkg::SPI_CMD;
            edge_cnt     <= 6'h00;
            cmd_sr       <= 8'h00;
            addr         <= 7'h00;
            wr_sr        <= 24'h000000;
            load_pending <= 1'b0;
        end else if (csb_f) begin
            // Deselected: wait for the next command
            state        <= rtd_pkg::SPI_CMD;
            edge_cnt     <= 6'h00;
            load_pending <= 1'b0;
        end else begin
            load_pending <= 1'b0;
            if (spi_rise) begin
                edge_cnt <= edge_no;
                case (state)
                    // Command byte: address then read flag
                    rtd_pkg::SPI_CMD: begin
                        cmd_sr <= {cmd_sr[6:0], sdi_bit};
                        if (edge_no == rtd_pkg::CMD_EDGES) begin
                            addr         <= cmd_sr[6:0];
                            state        <= sdi_bit ? rtd_pkg::SPI_READ : rtd_pkg::SPI_WRITE;
                            load_pending <= sdi_bit;
                        end
                    end
                    // burst continues, single ends after edge 32
                    rtd_pkg::SPI_READ: begin
                        if (word_end) begin
                            state        <= burst ? rtd_pkg::SPI_READ : rtd_pkg::SPI_DONE;
                            load_pending <= burst;
                        end
                    end
                    // Write data collects until edge 32
                    rtd_pkg::SPI_WRITE: begin
                        wr_sr <= wr_data;
                        if (word_end) state <= rtd_pkg::SPI_DONE;
                    end
                    // Extra clocks are ignored until deselect
                    rtd_pkg::SPI_DONE: begin
                    end
                    default: state <= rtd_pkg::SPI_CMD;
                endcase
            end
        end
    end

    // tag from FIFO state: overflow, empty, last, or stored tag bit 0 only
    assign head     = mem[rd_ptr[4:0]];
    assign head_tag = sample_fifo_overflow ? rtd_pkg::TAG_OVF :
                      fifo_empty ? rtd_pkg::TAG_EMPTY :
                      (fifo_count == 6'h01) ? {2'h1, head.tag[0]} : {2'h0, head.tag[0]};

    assign read_word = is_fifo_addr ? {head.voltage, head_tag, head.aux} :
        (addr == rtd_pkg::ADDR_GAIN_CFG)   ? gain_cfg :
        (addr == rtd_pkg::ADDR_TIMING_CFG) ? timing_cfg :
        (addr == rtd_pkg::ADDR_INTERVAL)   ? {beat_interval, 10'h000} : 24'h000000;

    // Read shifter: load after a read command or a burst word end, shift on falling SCLK
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_sr  <= 24'h000000;
            sdo    <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= ~csb_f;
            if (load_pending) begin
                rd_sr <= read_word;
            end else if (spi_fall && state == rtd_pkg::SPI_READ) begin
                sdo   <= rd_sr[23];
                rd_sr <= {rd_sr[22:0], 1'b0};
            end
        end
    end

    // Config registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            gain_cfg   <= rtd_pkg::GAIN_CFG_RST;
            timing_cfg <= rtd_pkg::TIMING_CFG_RST;
        end else if (cfg_write && addr == rtd_pkg::ADDR_GAIN_CFG) begin
            gain_cfg   <= wr_data & rtd_pkg::GAIN_CFG_MASK;
        end else if (cfg_write && addr == rtd_pkg::ADDR_TIMING_CFG) begin
            timing_cfg <= wr_data & rtd_pkg::TIMING_CFG_MASK;
        end
    end

    a_cfg_unused: assert property ((gain_cfg & ~rtd_pkg::GAIN_CFG_MASK) == 24'h000000 &&
        (timing_cfg & ~rtd_pkg::TIMING_CFG_MASK) == 24'h000000)
        else $error("unused config bit set");

    // Sample buffer in front of the FIFO; stalls while the read pointer moves
    rtd_buf2 #(.WIDTH(24)) u_buf (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (sample_in_valid),
        .in_ready  (sample_in_ready),
        .in_data   (sample_in),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_data)
    );

    // FIFO bookkeeping
    assign fifo_count     = wr_ptr - rd_ptr;
    assign fifo_full      = fifo_count == 6'h20;
    assign fifo_empty     = fifo_count == 6'h00;
    assign fifo_clear     = fifo_reset_cmd | resync_cmd;
    assign buf_out_ready  = ~fifo_pop & ~fifo_clear;
    assign fifo_accept    = buf_out_valid & buf_out_ready;
    assign fifo_push      = fifo_accept & ~fifo_full;
    assign fifo_push_full = fifo_accept & fifo_full;
    assign thr_n          = {1'b0, sample_fifo_irq_threshold} + 6'h01;
    // pointer moves only past an unread, uncorrupted sample
    assign fifo_pop = spi_rise & (state == rtd_pkg::SPI_READ) & word_end &
                      is_fifo_addr & ~fifo_empty & ~sample_fifo_overflow;

    // pointers, overflow flag, clear by host command
    always_ff @(posedge clk_sys) begin
        if (!rst_n || fifo_clear) begin
            wr_ptr               <= 6'h00;
            rd_ptr               <= 6'h00;
            sample_fifo_overflow <= 1'b0;
            sample_fifo_irq      <= 1'b0;
        end else begin
            if (fifo_push) wr_ptr <= wr_ptr + 6'h01;
            if (fifo_push_full) sample_fifo_overflow <= 1'b1;
            // advance at the word's last edge
            if (fifo_pop) rd_ptr <= rd_ptr + 6'h01;
            sample_fifo_irq <= fifo_count >= thr_n;
        end
    end

    // Sample storage, not reset
    always_ff @(posedge clk_sys) begin
        if (fifo_push) mem[wr_ptr[4:0]] <= buf_data;
    end

    sequence s_word_end;
        spi_rise && word_end && state == rtd_pkg::SPI_READ;
    endsequence
    a_single_stop: assert property (s_word_end ##0 !burst |=>
        state == rtd_pkg::SPI_DONE)
        else $error("single read did not stop after one word");
    a_ptr_step: assert property (rd_ptr != $past(rd_ptr) && !$past(fifo_clear) |->
        rd_ptr == $past(rd_ptr) + 6'h01)
        else $error("read pointer moved other than by one");
    a_ovf_set: assert property (fifo_push_full |=> sample_fifo_overflow ##1
        (sample_fifo_overflow || $past(fifo_clear)))
        else $error("overflow not flagged");
    a_irq_level: assert property (!fifo_clear |=> sample_fifo_irq ==
        ($past(fifo_count) >= $past(thr_n)))
        else $error("fifo interrupt term wrong");
    a_empty_tag: assert property (load_pending && is_fifo_addr && fifo_empty &&
        !sample_fifo_overflow |=> rd_sr[5:3] == rtd_pkg::TAG_EMPTY)
        else $error("empty read not tagged");

    assign det_on     = gain_cfg[rtd_pkg::EN_BIT] & ecg_channel_enable;
    assign det_sample = fifo_accept & det_on;
    assign mag        = buf_data.voltage[17] ? 18'(-buf_data.voltage) : buf_data.voltage;
    // gain 2^code, auto-scale boosts small peaks
    assign gain_code  = gain_cfg[rtd_pkg::GAIN_LSB +: 4];
    assign gain_shift = (gain_code != rtd_pkg::GAIN_AUTO) ? gain_code :
                        (peak_avg < rtd_pkg::AUTO_LOW) ? rtd_pkg::AUTO_SHIFT : 4'h0;
    assign scaled     = rtd_gain(mag, gain_shift);
    assign win_len    = rtd_pkg::WIN_BASE + {1'b0, gain_cfg[rtd_pkg::AVG_WINDOW_WIDTH_LSB +: 4], 1'b0};
    assign win_close  = det_on & detect_tick & (win_ticks + 6'h01 == win_len);
    assign feature    = (|win_acc[31:28]) ? 24'hFFFFFF : win_acc[27:4];
    assign thr_prod   = {5'h00, peak_avg} *
                        {24'h000000, {1'b0, gain_cfg[rtd_pkg::PEAK_THRESHOLD_SCALE_LSB +: 4]} + 5'h01};
    // dynamic part, zero when code is 000
    assign dyn_prod   = {3'h0, interval_avg} * {14'h0000, timing_cfg[rtd_pkg::HOLDOFF_SCALE_LSB +: 3]};
    // larger of static and dynamic hold-off
    assign holdoff    = ({8'h00, timing_cfg[rtd_pkg::MIN_HOLDOFF_LSB +: 6]} > dyn_prod[16:3]) ?
                        {8'h00, timing_cfg[rtd_pkg::MIN_HOLDOFF_LSB +: 6]} : dyn_prod[16:3];
    assign beat       = win_close & ({1'b0, feature} > thr_prod[28:4]) & (interval_cnt >= holdoff);
    assign next_interval_avg = rtd_wavg({10'h000, interval_cnt}, {10'h000, interval_avg},
                                        timing_cfg[rtd_pkg::INTERVAL_AVG_WEIGHT_LSB +: 2]);

    // Window integration and interval timing
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !det_on) begin
            win_acc      <= 32'h00000000;
            win_ticks    <= 6'h00;
            interval_cnt <= 14'h0000;
        end else begin
            if (win_close) begin
                win_acc   <= 32'h00000000;
                win_ticks <= 6'h00;
            end else begin
                if (det_sample) win_acc <= win_acc + {8'h00, scaled};
                if (detect_tick) win_ticks <= win_ticks + 6'h01;
            end
            if (beat) interval_cnt <= 14'h0000;
            else if (detect_tick && interval_cnt != 14'h3FFF) interval_cnt <= interval_cnt + 14'h0001;
        end
    end

    // results and beat interrupt; a new beat wins over a clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            beat_interval <= 14'h0000;
            interval_avg  <= 14'h0000;
            peak_avg      <= 24'h000000;
            beat_irq      <= 1'b0;
        end else if (beat) begin
            beat_interval <= interval_cnt;
            interval_avg  <= next_interval_avg[13:0];
            peak_avg      <= rtd_wavg(feature, peak_avg, gain_cfg[rtd_pkg::PEAK_AVG_WEIGHT_LSB +: 2]);
            beat_irq      <= 1'b1;
        end else if (beat_irq_clear) begin
            beat_irq      <= 1'b0;
        end
    end

    a_detect_gate: assert property (!det_on |-> !beat ##1 interval_cnt == 14'h0000)
        else $error("detector ran while disabled");
    a_beat_report: assert property (beat |=> beat_irq && interval_cnt == 14'h0000 &&
        beat_interval == $past(interval_cnt) && beat_interval >= $past(holdoff))
        else $error("beat not reported");
endmodule

// ===== core/rtd_pkg.sv
// Shared constants and types for the beat-interval detector block.
// Assumes nothing beyond a SystemVerilog-2012 compiler.
package rtd_pkg;

    // Register addresses carried by the SPI command byte
    localparam logic [6:0]  ADDR_GAIN_CFG    = 7'h1D;
    localparam logic [6:0]  ADDR_TIMING_CFG  = 7'h1E;
    localparam logic [6:0]  ADDR_FIFO_BURST  = 7'h20;
    localparam logic [6:0]  ADDR_FIFO_SINGLE = 7'h21;
    localparam logic [6:0]  ADDR_INTERVAL    = 7'h25;

    // Reset values and writable-bit masks of the two config registers
    localparam logic [23:0] GAIN_CFG_RST     = 24'h3F2300;
    localparam logic [23:0] GAIN_CFG_MASK    = 24'hFFBF00;
    localparam logic [23:0] TIMING_CFG_RST   = 24'h202400;
    localparam logic [23:0] TIMING_CFG_MASK  = 24'h3F3700;

    // Field positions in the gain/threshold register
    localparam int unsigned AVG_WINDOW_WIDTH_LSB = 20;
    localparam int unsigned GAIN_LSB = 16;
    localparam int unsigned EN_BIT   = 15;
    localparam int unsigned PEAK_AVG_WEIGHT_LSB = 12;
    localparam int unsigned PEAK_THRESHOLD_SCALE_LSB = 8;
    // Field positions in the timing register
    localparam int unsigned MIN_HOLDOFF_LSB = 16;
    localparam int unsigned INTERVAL_AVG_WEIGHT_LSB = 12;
    localparam int unsigned HOLDOFF_SCALE_LSB = 8;

    // Window width base, in detector time units; the step of 2 per code is applied in rtd_core
    localparam logic [5:0]  WIN_BASE   = 6'h06;
    // Gain code that selects auto-scaling, and its behaviour
    localparam logic [3:0]  GAIN_AUTO  = 4'hF;
    localparam logic [3:0]  AUTO_SHIFT = 4'h4;
    localparam logic [23:0] AUTO_LOW   = 24'h001000;

    // Sample tags
    localparam logic [2:0]  TAG_VALID      = 3'h0;
    localparam logic [2:0]  TAG_FAST       = 3'h1;
    localparam logic [2:0]  TAG_VALID_LAST = 3'h2;
    localparam logic [2:0]  TAG_FAST_LAST  = 3'h3;
    localparam logic [2:0]  TAG_EMPTY      = 3'h6;
    localparam logic [2:0]  TAG_OVF        = 3'h7;

    // SPI frame: command edges, and the edge that ends each data word
    localparam logic [5:0]  CMD_EDGES      = 6'h08;
    localparam logic [5:0]  WORD_END_EDGE  = 6'h20;
    localparam logic [5:0]  NEXT_WORD_EDGE = 6'h09;

    // One stored ECG sample
    typedef struct packed {
        logic [17:0] voltage;
        logic [2:0]  tag;
        logic [2:0]  aux;
    } rtd_sample_t;

    // SPI transaction phase
    typedef enum logic [3:0] {
        SPI_CMD   = 4'b0001,
        SPI_READ  = 4'b0010,
        SPI_WRITE = 4'b0100,
        SPI_DONE  = 4'b1000
    } rtd_spi_state_t;

endpackage

// ===== dv/rtd_core_tb_top.sv
// Bench for rtd_core: config, FIFO, tags and overflow over SPI.
// Assumes rtd_spi_host plays the host.
`timescale 1ns/100ps
module rtd_core_tb_top;
    logic clk_sys = 1'h0, rst_n = 1'h0, v = 1'h0, tick = 1'h0, frst = 1'h0, rsync = 1'h0;
    logic sclk, csb_n, sdi, sdo, rdy, fi, ovf, bi, oe;
    logic een = 1'h0, bclr = 1'h0; // Channel enable, beat interrupt clear
    rtd_pkg::rtd_sample_t smp = '0; // Sample word driven in
    int num_errors = 0, total_checks = 0;
    always #2 clk_sys = ~clk_sys;
    rtd_spi_host i_rtd_spi_host (.sclk(sclk), .csb_n(csb_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe(oe));
    rtd_core i_rtd_core (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .csb_n(csb_n),
        .sdi(sdi), .sdo(sdo), .sdo_oe(oe), .sample_in_valid(v), .sample_in_ready(rdy),
        .sample_in(smp), .detect_tick(tick), .ecg_channel_enable(een),
        .fifo_reset_cmd(frst), .resync_cmd(rsync), .sample_fifo_irq_threshold(5'h02),
        .sample_fifo_irq(fi), .sample_fifo_overflow(ovf), .beat_irq(bi), .beat_irq_clear(bclr));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [6:0] a, input int nw);
        i_rtd_spi_host.frame({a, 1'h1}, 24'h000000, nw);
    endtask
    // Offer one sample, held until taken, then drop valid
    task automatic push(input logic [23:0] s);
        @(negedge clk_sys);
        v = 1'h1;
        smp = s;
        do @(posedge clk_sys); while (rdy !== 1'h1);
        @(negedge clk_sys) v = 1'h0;
        repeat (6) @(negedge clk_sys);
    endtask
    task automatic final_report;
        $display("Errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #300000;
        num_errors++;
        final_report;
    end
    initial begin
        repeat (20) @(negedge clk_sys);
        rst_n = 1'h1;
        repeat (8) @(negedge clk_sys);
        rd(rtd_pkg::ADDR_GAIN_CFG, 1);
        chk(i_rtd_spi_host.rw[0], 24'h3F2300);
        chk(oe, 1'h0);
        rd(rtd_pkg::ADDR_TIMING_CFG, 1);
        chk(i_rtd_spi_host.rw[0], 24'h202400);
        // All-ones writes keep only the defined fields
        for (int r = 0; r < 2; r++) begin
            i_rtd_spi_host.frame({r ? 7'h1E : 7'h1D, 1'h0}, 24'hFFFFFF, 1);
            rd(r ? 7'h1E : 7'h1D, 1);
            chk(i_rtd_spi_host.rw[0], r ? 24'h3F3700 : 24'hFFBF00);
        end
        // Enable bit set but channel off: no beats
        repeat (40) begin
            @(negedge clk_sys) tick = 1'h1;
            @(negedge clk_sys) tick = 1'h0;
        end
        chk(bi, 1'h0);
        rd(rtd_pkg::ADDR_INTERVAL, 1);
        chk(i_rtd_spi_host.rw[0][9:0], 10'h000);
        rd(rtd_pkg::ADDR_FIFO_SINGLE, 1);
        chk(i_rtd_spi_host.rw[0][5:3], 3'h6);
        for (int k = 0; k < 3; k++) begin
            push({16'hA5C0, k[1:0], (k == 1) ? 6'h08 : 6'h00});
            chk(fi, k == 2);
        end
        rd(rtd_pkg::ADDR_FIFO_BURST, 3);
        for (int k = 0; k < 3; k++)
            chk(i_rtd_spi_host.rw[k], {16'hA5C0, k[1:0], 6'(k * 8)});
        rd(rtd_pkg::ADDR_FIFO_SINGLE, 1);
        chk(i_rtd_spi_host.rw[0][5:3], 3'h6);
        chk(fi, 1'h0);
        // Overflow, then each clear command in turn
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 34; k++) begin
                push(24'h123440);
                if (k == 31) chk(ovf, 1'h0);
            end
            chk(ovf, 1'h1);
            rd(rtd_pkg::ADDR_FIFO_SINGLE, 1);
            chk(i_rtd_spi_host.rw[0][5:3], 3'h7);
            @(negedge clk_sys);
            if (c == 0) frst = 1'h1;
            else rsync = 1'h1;
            @(negedge clk_sys) {frst, rsync} = 2'h0;
            repeat (8) @(negedge clk_sys);
            chk(ovf, 1'h0);
        end
        // Detector on: the first window's peak is held off, the second reports
        @(negedge clk_sys) een = 1'h1;
        for (int k = 0; k < 72; k++) begin
            if (k == 0 || k == 40) push(24'h004000);
            if (k == 40) chk(bi, 1'h0);
            @(negedge clk_sys) tick = 1'h1;
            @(negedge clk_sys) tick = 1'h0;
        end
        chk(bi, 1'h1);
        rd(rtd_pkg::ADDR_INTERVAL, 1);
        chk(i_rtd_spi_host.rw[0], 24'h011C00);
        @(negedge clk_sys) bclr = 1'h1;
        @(negedge clk_sys) bclr = 1'h0;
        chk(bi, 1'h0);
        final_report;
    end
endmodule

// ===== dv/rtd_spi_host.sv
// SPI mode-0 host model for rtd_core.
// Assumes SDO shifts after each SCLK fall.
`timescale 1ns/100ps
module rtd_spi_host (
    // SPI pins
    output logic sclk,
    output logic csb_n,
    output logic sdi,
    input  wire  sdo,
    input  wire  sdo_oe
);
    logic [23:0] rw [0:3]; // Words read in the last frame
    initial {sclk, csb_n, sdi} = 3'h2;
    task automatic frame(input logic [7:0] cmd, input logic [23:0] wd, input int nw);
        csb_n = 1'h0;
        #80;
        for (int i = 0; i < 8 + 24 * nw; i++) begin
            sdi = (i < 8) ? cmd[7 - i] : wd[23 - (i - 8) % 24];
            #80 sclk = 1'h1;
            // An undriven data line shows the inverse of the last level
            if (i >= 8) rw[(i - 8) / 24][23 - (i - 8) % 24] = sdo_oe ? sdo : ~sdo;
            #80 sclk = 1'h0;
        end
        #80 csb_n = 1'h1;
        sdi = ~sdi; // Released line never keeps its last level
        #240;
    endtask
endmodule
